// *** osc_consts.svh ***
// Register offsets, field positions, reset values and line limits of the display control block
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OSC_ADDR_ROW_START 16'h001e
`define OSC_ADDR_ROW_END 16'h001f
`define OSC_ADDR_LINE_COUNT 16'h0045
`define OSC_ADDR_STATUS 16'h0046
`define OSC_ADDR_POLARITY 16'hfe0a

// ---------------------------------------------------------------
// Pin polarity control fields
// ---------------------------------------------------------------
`define OSC_POL_HSYNC 6
`define OSC_POL_VSYNC 5
`define OSC_POL_FIELD 4
`define OSC_POL_COLOUR 3
`define OSC_POL_FBLANK 2
`define OSC_POL_INTENS 1
`define OSC_POL_MASK 8'h7e

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define OSC_ST_MATCH 7
`define OSC_ST_VSEDGE 6
`define OSC_ST_HSVIEW 5
`define OSC_ST_VSVIEW 4
`define OSC_ST_VCO 2
`define OSC_ST_SLICER 1
`define OSC_ST_PLL 0

// ---------------------------------------------------------------
// Row start and row end fields and line limits
// ---------------------------------------------------------------
`define OSC_RS_MODE 6
`define OSC_RS_BLINK 5
`define OSC_RS_MASK 8'h7f
`define OSC_RE_MASK 8'h1f
`define OSC_MAX_LINE_CAPTION 5'h0c
`define OSC_MAX_LINE_OSD 5'h11

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define OSC_RST_BYTE 8'h00

`endif

// *** osc_pkg.sv ***
// Types shared by the display control block
package osc_pkg;

	// ---------------------------------------------------------------
	// Register port request
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} osc_bus_req_t;

	// ---------------------------------------------------------------
	// One pixel of video towards the mixer
	// ---------------------------------------------------------------
	typedef struct packed {
		logic red;
		logic green;
		logic blue;
		logic intensity;
		logic fast_blank;
	} osc_pixel_t;

	// Rendering mode of a row
	typedef enum logic {
		OSC_MODE_OSD,
		OSC_MODE_CAPTION
	} osc_mode_t;

endpackage : osc_pkg

// *** osc_sync_edge.sv ***
// Two-stage synchroniser with polarity correction and leading edge detect
module osc_sync_edge (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic pin,
	input wire logic invert,
	output logic level_r,
	output logic lead
);

	logic meta_r;
	logic stable_r;
	logic prev_r;

	// First stage read only by the second one
	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_r <= 1'b0;
			stable_r <= 1'b0;
		end else begin
			meta_r <= pin;
			stable_r <= meta_r;
		end
	end

	// Polarity applied after the synchroniser
	always_ff @(posedge core_clk) begin
		if (reset) begin
			level_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			level_r <= stable_r ^ invert;
			prev_r <= level_r;
		end
	end

	// Flipping the polarity can fake one edge; software does it only outside sync
	assign lead = level_r & ~prev_r;

endmodule : osc_sync_edge

// *** osc_row_rank.sv ***
// Double-ranked row register: software rank plus working rank
module osc_row_rank #(
	parameter int WIDTH = 8
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic copy,
	output logic [WIDTH-1:0] ext_r,
	output logic [WIDTH-1:0] int_r
);

	// Software rank
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ext_r <= '0;
		end else if (wr) begin
			ext_r <= wdata;
		end
	end

	// Working rank; a write in the copy cycle is taken straight through
	always_ff @(posedge core_clk) begin
		if (reset) begin
			int_r <= '0;
		end else if (copy) begin
			int_r <= wr ? wdata : ext_r;
		end
	end

endmodule : osc_row_rank

// *** osc_top.sv ***
// Display sync, polarity, status and row control with its register port
`include "osc_consts.svh"

module osc_top (
	input wire logic core_clk,
	input wire logic reset,
	input osc_pkg::osc_bus_req_t bus_req,
	output logic [7:0] bus_rdata_r,
	input wire logic hsync_pin,
	input wire logic vsync_pin,
	input wire logic caption_slicer_field,
	input wire logic pll_clk_pin,
	input wire logic [7:0] event_line_target,
	input wire logic line_match_irq_en,
	input wire logic vsync_irq_en,
	input wire logic rank_copy_en,
	input wire logic global_flash_phase,
	input wire logic peripheral_test_mode,
	input wire logic cpu_test_mode,
	input wire logic cpu_wait,
	input wire logic cpu_stop,
	input wire logic [4:0] row_line_idx,
	input osc_pkg::osc_pixel_t fg_pix,
	input osc_pkg::osc_pixel_t bg_pix,
	input wire logic ctrl_char_valid,
	input wire logic [1:0] ctrl_char_attr,
	output osc_pkg::osc_pixel_t pix_out_r,
	output logic field_out_r,
	output logic row_render_mode_r,
	output logic slicer_analog_test_r,
	output logic pll_self_test_r,
	output logic osd_irq_r
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [7:0] polarity_r;
	logic [7:0] line_count_value_r;
	logic line_update_r;
	logic line_match_flag_r;
	logic vsync_edge_flag_r;
	logic vco_observe_test_r;
	logic pll_half_r;
	logic row_blink_r;
	logic [7:0] row_start_ext;
	logic [7:0] row_start_int;
	logic [7:0] row_end_ext;
	logic [7:0] row_end_int;
	logic hsync_level_view;
	logic vsync_level_view;
	logic hsync_lead;
	logic vsync_lead;
	logic field_level;
	logic pll_lead;
	logic match_hit;
	logic rank_copy;
	logic test_mode;
	logic wr_status;
	logic wr_row_start;
	logic wr_row_end;
	logic wr_polarity;
	logic row_visible;
	logic [7:0] rdata_nxt;
	osc_pkg::osc_mode_t mode;
	osc_pkg::osc_pixel_t pix_nxt;

	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------
	// Highest line number a row may use in the given mode
	function automatic logic [4:0] osc_max_line(input osc_pkg::osc_mode_t m);
		osc_max_line = (m == osc_pkg::OSC_MODE_CAPTION) ? `OSC_MAX_LINE_CAPTION : `OSC_MAX_LINE_OSD;
	endfunction : osc_max_line

	// Address compare used by every write decode
	function automatic logic osc_hit(input logic [15:0] a, input logic [15:0] target);
		osc_hit = (a == target);
	endfunction : osc_hit

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	osc_sync_edge u_hsync (
		.core_clk(core_clk),
		.reset(reset),
		.pin(hsync_pin),
		.invert(polarity_r[`OSC_POL_HSYNC]),
		.level_r(hsync_level_view),
		.lead(hsync_lead)
	);

	osc_sync_edge u_vsync (
		.core_clk(core_clk),
		.reset(reset),
		.pin(vsync_pin),
		.invert(polarity_r[`OSC_POL_VSYNC]),
		.level_r(vsync_level_view),
		.lead(vsync_lead)
	);

	osc_sync_edge u_field (
		.core_clk(core_clk),
		.reset(reset),
		.pin(caption_slicer_field),
		.invert(polarity_r[`OSC_POL_FIELD]),
		.level_r(field_level),
		.lead()
	);

	osc_sync_edge u_pll (
		.core_clk(core_clk),
		.reset(reset),
		.pin(pll_clk_pin),
		.invert(1'b0),
		.level_r(),
		.lead(pll_lead)
	);

	// ---------------------------------------------------------------
	// Write decode
	// ---------------------------------------------------------------
	assign test_mode = peripheral_test_mode | cpu_test_mode;
	assign wr_status = bus_req.wr & osc_hit(bus_req.addr, `OSC_ADDR_STATUS);
	assign wr_row_start = bus_req.wr & osc_hit(bus_req.addr, `OSC_ADDR_ROW_START);
	assign wr_row_end = bus_req.wr & osc_hit(bus_req.addr, `OSC_ADDR_ROW_END);
	assign wr_polarity = bus_req.wr & osc_hit(bus_req.addr, `OSC_ADDR_POLARITY);

	// Polarity register; unimplemented bits stay zero
	always_ff @(posedge core_clk) begin
		if (reset) begin
			polarity_r <= `OSC_RST_BYTE;
		end else if (wr_polarity) begin
			polarity_r <= bus_req.wdata & `OSC_POL_MASK;
		end
	end

	// ---------------------------------------------------------------
	// Scan line counter and line match
	// ---------------------------------------------------------------
	// Vertical sync restarts the field, each horizontal sync steps it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			line_count_value_r <= `OSC_RST_BYTE;
			line_update_r <= 1'b0;
		end else begin
			line_update_r <= vsync_lead | hsync_lead;
			if (vsync_lead) begin
				line_count_value_r <= 8'h00;
			end else if (hsync_lead) begin
				line_count_value_r <= line_count_value_r + 8'h01;
			end
		end
	end

	// Checked only once per new line so a slow line yields one event
	assign match_hit = line_update_r & (line_count_value_r == event_line_target);
	assign rank_copy = match_hit & rank_copy_en;

	// ---------------------------------------------------------------
	// Status flags and test bits
	// ---------------------------------------------------------------
	// A new event in the clearing cycle wins over the write
	always_ff @(posedge core_clk) begin
		if (reset) begin
			line_match_flag_r <= 1'b0;
			vsync_edge_flag_r <= 1'b0;
		end else begin
			line_match_flag_r <= match_hit | (line_match_flag_r & ~wr_status);
			vsync_edge_flag_r <= vsync_lead | (vsync_edge_flag_r & ~wr_status);
		end
	end

	// Test bits ignore writes outside test mode
	always_ff @(posedge core_clk) begin
		if (reset) begin
			vco_observe_test_r <= 1'b0;
			slicer_analog_test_r <= 1'b0;
			pll_self_test_r <= 1'b0;
		end else if (wr_status && test_mode) begin
			vco_observe_test_r <= bus_req.wdata[`OSC_ST_VCO];
			slicer_analog_test_r <= bus_req.wdata[`OSC_ST_SLICER];
			pll_self_test_r <= bus_req.wdata[`OSC_ST_PLL];
		end
	end

	// One request line for both sources; held off while the core waits
	always_ff @(posedge core_clk) begin
		if (reset) begin
			osd_irq_r <= 1'b0;
		end else begin
			osd_irq_r <= ~cpu_wait & ((line_match_flag_r & line_match_irq_en) |
				(vsync_edge_flag_r & vsync_irq_en));
		end
	end

	// ---------------------------------------------------------------
	// Row registers
	// ---------------------------------------------------------------
	osc_row_rank #(
		.WIDTH(8)
	) u_row_start (
		.core_clk(core_clk),
		.reset(reset),
		.wr(wr_row_start),
		.wdata(bus_req.wdata & `OSC_RS_MASK),
		.copy(rank_copy),
		.ext_r(row_start_ext),
		.int_r(row_start_int)
	);

	osc_row_rank #(
		.WIDTH(8)
	) u_row_end (
		.core_clk(core_clk),
		.reset(reset),
		.wr(wr_row_end),
		.wdata(bus_req.wdata & `OSC_RE_MASK),
		.copy(rank_copy),
		.ext_r(row_end_ext),
		.int_r(row_end_int)
	);

	assign mode = row_start_int[`OSC_RS_MODE] ? osc_pkg::OSC_MODE_CAPTION : osc_pkg::OSC_MODE_OSD;

	// Mode output for the fetch path: matrix size and character store
	always_ff @(posedge core_clk) begin
		if (reset) begin
			row_render_mode_r <= 1'b0;
		end else begin
			row_render_mode_r <= row_start_int[`OSC_RS_MODE];
		end
	end

	// Blink starts from the row value; control characters may change it.
	// Caption codes carry blink in bit 0, display codes in bit 1.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			row_blink_r <= 1'b0;
		end else if (rank_copy || hsync_lead) begin
			row_blink_r <= rank_copy ? (wr_row_start ? bus_req.wdata[`OSC_RS_BLINK] :
				row_start_ext[`OSC_RS_BLINK]) : row_start_int[`OSC_RS_BLINK];
		end else if (ctrl_char_valid) begin
			row_blink_r <= (mode == osc_pkg::OSC_MODE_CAPTION) ? ctrl_char_attr[0] :
				ctrl_char_attr[1];
		end
	end

	// Lines past the mode limit are never shown; the limit shows the last line
	assign row_visible = (row_line_idx >= row_start_int[4:0]) &&
		(row_line_idx <= row_end_int[4:0]) &&
		(row_line_idx <= osc_max_line(mode));

	// ---------------------------------------------------------------
	// Video output
	// ---------------------------------------------------------------
	// Half PLL rate divider for the observation test
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pll_half_r <= 1'b0;
		end else if (pll_lead) begin
			pll_half_r <= ~pll_half_r;
		end
	end

	// Logical pixel, then pin polarity; stop mode leaves no fetch data
	always_comb begin
		pix_nxt = '0;
		if (!cpu_stop && row_visible) begin
			pix_nxt = (row_blink_r && global_flash_phase) ? bg_pix : fg_pix;
		end
		pix_nxt.red = pix_nxt.red ^ polarity_r[`OSC_POL_COLOUR];
		pix_nxt.green = pix_nxt.green ^ polarity_r[`OSC_POL_COLOUR];
		pix_nxt.blue = pix_nxt.blue ^ polarity_r[`OSC_POL_COLOUR];
		pix_nxt.intensity = pix_nxt.intensity ^ polarity_r[`OSC_POL_INTENS];
		pix_nxt.fast_blank = vco_observe_test_r ? pll_half_r :
			(pix_nxt.fast_blank ^ polarity_r[`OSC_POL_FBLANK]);
	end

	// Registered pins for clean edges at the mixer
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pix_out_r <= '0;
			field_out_r <= 1'b0;
		end else begin
			pix_out_r <= pix_nxt;
			field_out_r <= field_level;
		end
	end

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	// Unmapped addresses read zero
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (bus_req.addr)
			`OSC_ADDR_ROW_START: rdata_nxt = row_start_ext;
			`OSC_ADDR_ROW_END: rdata_nxt = row_end_ext;
			`OSC_ADDR_LINE_COUNT: rdata_nxt = line_count_value_r;
			`OSC_ADDR_POLARITY: rdata_nxt = polarity_r;
			`OSC_ADDR_STATUS: begin
				rdata_nxt[`OSC_ST_MATCH] = line_match_flag_r;
				rdata_nxt[`OSC_ST_VSEDGE] = vsync_edge_flag_r;
				rdata_nxt[`OSC_ST_HSVIEW] = hsync_level_view;
				rdata_nxt[`OSC_ST_VSVIEW] = vsync_level_view;
				rdata_nxt[`OSC_ST_VCO] = vco_observe_test_r;
				rdata_nxt[`OSC_ST_SLICER] = slicer_analog_test_r & test_mode;
				rdata_nxt[`OSC_ST_PLL] = pll_self_test_r & test_mode;
			end
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bus_rdata_r <= 8'h00;
		end else begin
			bus_rdata_r <= bus_req.rd ? rdata_nxt : 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	AST_LINE_COUNT_READ: assert property (
		bus_req.rd && bus_req.addr == `OSC_ADDR_LINE_COUNT |=> bus_rdata_r == $past(line_count_value_r))
		else $error("line count read mismatch");

	AST_VSYNC_FLAG_SET: assert property (
		vsync_lead |=> vsync_edge_flag_r)
		else $error("vsync flag not set");

	AST_MATCH_FLAG_SET: assert property (
		line_update_r && line_count_value_r == event_line_target |=> line_match_flag_r)
		else $error("line match flag not set");

	AST_STATUS_CLEAR: assert property (
		wr_status && !match_hit && !vsync_lead |=> !line_match_flag_r && !vsync_edge_flag_r)
		else $error("status write did not clear flags");

	AST_IRQ_FOLLOWS: assert property (
		!cpu_wait && line_match_flag_r && line_match_irq_en |=> osd_irq_r)
		else $error("request missing for pending flag");

	AST_IRQ_WAIT: assert property (
		cpu_wait |=> !osd_irq_r)
		else $error("request raised in wait mode");

	AST_TEST_LOCK: assert property (
		wr_status && !test_mode |=> $stable(vco_observe_test_r))
		else $error("test bit written outside test mode");

	AST_FB_VCO: assert property (
		vco_observe_test_r && $stable(vco_observe_test_r) |=> pix_out_r.fast_blank == $past(pll_half_r))
		else $error("fast blank not carrying pll half rate");

	AST_COLOUR_POL: assert property (
		(cpu_stop || !row_visible) |=> pix_out_r.red == $past(polarity_r[`OSC_POL_COLOUR]))
		else $error("idle colour level wrong");

	AST_HSYNC_VIEW: assert property (
		bus_req.rd && bus_req.addr == `OSC_ADDR_STATUS |=> bus_rdata_r[`OSC_ST_HSVIEW] == $past(hsync_level_view))
		else $error("hsync view wrong");

	AST_RANK_COPY: assert property (
		rank_copy && !wr_row_end |=> row_end_int == $past(row_end_ext))
		else $error("rank copy missing");

	AST_RESET_CLEAR: assert property (
		disable iff (1'b0) reset |=> polarity_r == 8'h00 && !line_match_flag_r && !osd_irq_r)
		else $error("reset values not zero");

endmodule : osc_top

// *** osc_video_src.sv ***
// Behavioural sync source and PLL clock that drive the display control block pins
module osc_video_src (
	input wire logic core_clk,
	input wire logic hs_low,
	input wire logic vs_low,
	output logic hsync_pin,
	output logic vsync_pin,
	output logic pll_clk_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	logic h_act = 1'b0;
	logic v_act = 1'b0;
	logic pll_r = 1'b0;

	// Pin level is the logical pulse seen through the chosen polarity
	assign hsync_pin = h_act ^ hs_low;
	assign vsync_pin = v_act ^ vs_low;
	assign pll_clk_pin = pll_r;

	// Free-running oscillator, slow enough to be sampled as data
	always begin
		#20;
		pll_r = ~pll_r;
	end

	// One sync pulse, then a quiet gap so edges never merge
	task sync_pulse(input logic vert, input int width);
		@(posedge core_clk);
		if (vert) begin
			v_act <= 1'b1;
		end else begin
			h_act <= 1'b1;
		end
		repeat (width) @(posedge core_clk);
		v_act <= 1'b0;
		h_act <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask : sync_pulse
endmodule : osc_video_src

// *** osc_top_tb.sv ***
// Self-checking bench for the display sync, polarity, status and row control block
`include "osc_consts.svh"

module osc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk = 1'b0;
	logic reset = 1'b1;
	osc_pkg::osc_bus_req_t bus_req = '0;
	logic [7:0] bus_rdata_r;
	logic hsync_pin, vsync_pin, pll_clk_pin;
	logic field_in = 1'b0;
	logic [7:0] event_line_target = 8'hff;
	logic line_match_irq_en = 1'b0, vsync_irq_en = 1'b0, rank_copy_en = 1'b0;
	logic flash = 1'b0, periph_test = 1'b0, cpu_test = 1'b0, cpu_wait = 1'b0, cpu_stop = 1'b0;
	logic [4:0] row_idx = 5'h00;
	osc_pkg::osc_pixel_t fg = '0, bg = '0;
	logic ctl_valid = 1'b0;
	logic [1:0] ctl_attr = 2'h0;
	logic hs_low = 1'b0, vs_low = 1'b0;
	osc_pkg::osc_pixel_t pix_out_r;
	logic field_out_r, row_render_mode_r, slicer_analog_test_r, pll_self_test_r, osd_irq_r;
	logic saw_hi, saw_lo;
	int err_count = 0;
	int checks = 0;

	always #2.5 core_clk = ~core_clk;

	osc_video_src src (.core_clk(core_clk), .hs_low(hs_low), .vs_low(vs_low), .hsync_pin(hsync_pin),
		.vsync_pin(vsync_pin), .pll_clk_pin(pll_clk_pin));

	osc_top uut (.core_clk(core_clk), .reset(reset), .bus_req(bus_req), .bus_rdata_r(bus_rdata_r),
		.hsync_pin(hsync_pin), .vsync_pin(vsync_pin), .caption_slicer_field(field_in),
		.pll_clk_pin(pll_clk_pin), .event_line_target(event_line_target),
		.line_match_irq_en(line_match_irq_en), .vsync_irq_en(vsync_irq_en), .rank_copy_en(rank_copy_en),
		.global_flash_phase(flash), .peripheral_test_mode(periph_test), .cpu_test_mode(cpu_test),
		.cpu_wait(cpu_wait), .cpu_stop(cpu_stop), .row_line_idx(row_idx), .fg_pix(fg), .bg_pix(bg),
		.ctrl_char_valid(ctl_valid), .ctrl_char_attr(ctl_attr), .pix_out_r(pix_out_r), .field_out_r(field_out_r),
		.row_render_mode_r(row_render_mode_r), .slicer_analog_test_r(slicer_analog_test_r),
		.pll_self_test_r(pll_self_test_r), .osd_irq_r(osd_irq_r));

	// ---------------------------------------------------------------
	// Checking and bus tasks
	// ---------------------------------------------------------------
	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask : chk

	// Ends on the edge that takes the write, so stimulus may follow at once
	task wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task rd_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1;
		chk(name, bus_rdata_r, exp);
	endtask : rd_chk

	task settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : settle

	// Row position and flash phase change at an edge; the registered pixel is looked at two edges on
	task pix_chk(input string name, input logic [4:0] idx, input logic ph, input logic [7:0] exp);
		@(posedge core_clk);
		row_idx <= idx;
		flash <= ph;
		settle(2);
		chk(name, {3'h0, pix_out_r}, exp);
	endtask : pix_chk

	task close_out;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	// Run is a few hundred cycles; this limit only catches a hang
	initial begin
		repeat (5000) @(posedge core_clk);
		err_count++;
		close_out();
	end

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		rd_chk("row start", `OSC_ADDR_ROW_START, `OSC_RST_BYTE);
		rd_chk("polarity", `OSC_ADDR_POLARITY, `OSC_RST_BYTE);
		rd_chk("status", `OSC_ADDR_STATUS, `OSC_RST_BYTE);
		chk("irq", {7'h0, osd_irq_r}, 8'h00);
		wr_reg(16'h0047, 8'hff);
		rd_chk("unmapped", 16'h0047, 8'h00);
		// All polarities inverted; pins follow so idle stays idle
		wr_reg(`OSC_ADDR_POLARITY, 8'hff);
		hs_low <= 1'b1;
		vs_low <= 1'b1;
		cpu_stop <= 1'b1;
		flash <= 1'b1;
		rd_chk("polarity mask", `OSC_ADDR_POLARITY, `OSC_POL_MASK);
		settle(6);
		wr_reg(`OSC_ADDR_STATUS, 8'h00);
		rd_chk("inverted idle", `OSC_ADDR_STATUS, 8'h00);
		chk("pixel low", {3'h0, pix_out_r}, 8'h1f);
		chk("field inv", {7'h0, field_out_r}, 8'h01);
		// Colour inverted only
		wr_reg(`OSC_ADDR_POLARITY, 8'h08);
		hs_low <= 1'b0;
		vs_low <= 1'b0;
		settle(6);
		wr_reg(`OSC_ADDR_STATUS, 8'h00);
		chk("pixel colour", {3'h0, pix_out_r}, 8'h1c);
		chk("field thru", {7'h0, field_out_r}, 8'h00);
		cpu_stop <= 1'b0;
		vsync_irq_en <= 1'b1;
		fork
			src.sync_pulse(1'b1, 12);
			begin
				settle(5);
				rd_chk("in vsync", `OSC_ADDR_STATUS, 8'h50);
			end
		join
		chk("vsync irq", {7'h0, osd_irq_r}, 8'h01);
		rd_chk("count zero", `OSC_ADDR_LINE_COUNT, 8'h00);
		fork
			src.sync_pulse(1'b0, 12);
			begin
				settle(5);
				rd_chk("in hsync", `OSC_ADDR_STATUS, 8'h60);
			end
		join
		src.sync_pulse(1'b0, 4);
		src.sync_pulse(1'b0, 4);
		rd_chk("count three", `OSC_ADDR_LINE_COUNT, 8'h03);
		wr_reg(`OSC_ADDR_STATUS, 8'h00);
		settle(3);
		chk("irq cleared", {7'h0, osd_irq_r}, 8'h00);
		// Line match copies the software rank into the working rank
		wr_reg(`OSC_ADDR_ROW_START, 8'h40);
		vsync_irq_en <= 1'b0;
		line_match_irq_en <= 1'b1;
		rank_copy_en <= 1'b1;
		event_line_target <= 8'h02;
		chk("mode before", {7'h0, row_render_mode_r}, 8'h00);
		src.sync_pulse(1'b1, 4);
		src.sync_pulse(1'b0, 4);
		src.sync_pulse(1'b0, 4);
		rd_chk("match", `OSC_ADDR_STATUS, 8'hc0);
		chk("match irq", {7'h0, osd_irq_r}, 8'h01);
		chk("mode after", {7'h0, row_render_mode_r}, 8'h01);
		rd_chk("row start sw", `OSC_ADDR_ROW_START, 8'h40);
		@(posedge core_clk);
		cpu_wait <= 1'b1;
		settle(3);
		chk("wait irq", {7'h0, osd_irq_r}, 8'h00);
		@(posedge core_clk);
		cpu_wait <= 1'b0;
		settle(3);
		chk("woke irq", {7'h0, osd_irq_r}, 8'h01);
		wr_reg(`OSC_ADDR_STATUS, 8'h5a);
		settle(3);
		chk("any data ack", {7'h0, osd_irq_r}, 8'h00);
		rd_chk("flags gone", `OSC_ADDR_STATUS, 8'h00);
		// Test bits refused outside test mode, taken inside it
		wr_reg(`OSC_ADDR_STATUS, 8'h07);
		rd_chk("test refused", `OSC_ADDR_STATUS, 8'h00);
		chk("slicer off", {7'h0, slicer_analog_test_r}, 8'h00);
		@(posedge core_clk);
		periph_test <= 1'b1;
		wr_reg(`OSC_ADDR_STATUS, 8'h07);
		rd_chk("test taken", `OSC_ADDR_STATUS, 8'h07);
		chk("test outs", {6'h0, slicer_analog_test_r, pll_self_test_r}, 8'h03);
		// Fast blank idles low here, so any toggling is the PLL divider
		saw_hi = 1'b0;
		saw_lo = 1'b0;
		repeat (40) begin
			settle(1);
			if (pix_out_r.fast_blank === 1'b1) saw_hi = 1'b1;
			if (pix_out_r.fast_blank === 1'b0) saw_lo = 1'b1;
		end
		chk("vco toggles", {6'h0, saw_hi, saw_lo}, 8'h03);
		@(posedge core_clk);
		periph_test <= 1'b0;
		cpu_test <= 1'b1;
		wr_reg(`OSC_ADDR_STATUS, 8'h00);
		settle(1);
		chk("test cleared", {6'h0, slicer_analog_test_r, pll_self_test_r}, 8'h00);
		// Display mode row, blink on, lines 2 to 5, taken into the working rank at the next match
		wr_reg(`OSC_ADDR_ROW_START, 8'h22);
		wr_reg(`OSC_ADDR_ROW_END, 8'h05);
		fg <= 5'h15;
		bg <= 5'h0a;
		src.sync_pulse(1'b1, 4);
		src.sync_pulse(1'b0, 4);
		src.sync_pulse(1'b0, 4);
		// Colour pins still inverted, so red, green and blue read flipped
		pix_chk("row blinked", 5'h03, 1'b1, 8'h16);
		chk("mode osd", {7'h0, row_render_mode_r}, 8'h00);
		pix_chk("flash off", 5'h03, 1'b0, 8'h09);
		pix_chk("above row", 5'h01, 1'b0, 8'h1c);
		pix_chk("below row", 5'h06, 1'b0, 8'h1c);
		pix_chk("last line", 5'h05, 1'b0, 8'h09);
		// Display mode takes blink from bit 1 of a mid-row control character
		@(posedge core_clk);
		ctl_valid <= 1'b1;
		ctl_attr <= 2'h1;
		@(posedge core_clk);
		ctl_valid <= 1'b0;
		pix_chk("mid-row kept", 5'h05, 1'b1, 8'h09);
		@(posedge core_clk);
		ctl_valid <= 1'b1;
		ctl_attr <= 2'h2;
		@(posedge core_clk);
		ctl_valid <= 1'b0;
		pix_chk("mid-row blink", 5'h05, 1'b1, 8'h16);
		close_out();
	end
endmodule : osc_top_tb
